// ==== vio_pkg.sv ====
// Operation
// (RULE1) Select bits 1:0 pick black, PLL path, EQ path or color bars.
// (RULE2) Raster bits 0000 give NTSC 4:3 at 27 MHz.
// (RULE3) Raster bits 0100 give PAL 4:3 at 27 MHz.
// (RULE4) Raster bits 0001 give NTSC 16:9 at 36 MHz.
// (RULE5) Raster bits 0101 give PAL 16:9 at 36 MHz.
// (RULE6) Raster bits 0010 give NTSC at 54 MHz.
// (RULE7) Raster bits 0110 give PAL at 54 MHz.
// (RULE8) SD self-test uses NTSC 4:3 bars and PAL 4:3 PLL path.
// (RULE9) HD self-test uses color bars of each HD format; the code shows bars of the selected HD raster only, for one cycle.
// (RULE10) Each pin takes a six-bit function address fixing function and direction.
// (RULE11) Address 00 reserved; 01 to 04 output EDH flags and CRC error.
// (RULE12) Addresses 05h up to the SAV address are reserved.
// (RULE13) 0Dh..0Fh give SAV, EAV, new sync; 11h H bit, 12h F bit.
// (RULE14) 15h..19h output format code bits 0 to 4.
// (RULE15) 1Ah..1Fh output FIFO full, empty, lock, pass, overrun, checksum error.
// (RULE16) 20h..28h are inputs: EDH force, select 0..5, EDH enable, generator enable.
// (RULE17) 2Ah, 2Ch, 2Dh, 2Fh are checksum, band limit, dither, insert inputs.
// (RULE18) Reset defaults: CRC on bit 5, pass on 6, enable on 7, format4 on 3.
// (RULE19) A reserved address neither drives nor controls anything.
// (RULE20) Select bit 5 set means HD: bits 4:2 raster, bits 1:0 pattern.
package vio_pkg;
	localparam int NPINS = 8;
	localparam int AW = 6;
	typedef logic [AW-1:0] vio_addr_t;
	localparam vio_addr_t FA_FF_ERR = 6'h01;
	localparam vio_addr_t FA_AP_ERR = 6'h02;
	localparam vio_addr_t FA_ANC_ERR = 6'h03;
	localparam vio_addr_t FA_CRC_ERR = 6'h04;
	localparam vio_addr_t FA_SAV = 6'h0D;
	localparam vio_addr_t FA_EAV = 6'h0E;
	localparam vio_addr_t FA_NSYNC = 6'h0F;
	localparam vio_addr_t FA_H = 6'h11;
	localparam vio_addr_t FA_F = 6'h12;
	localparam vio_addr_t FA_FMT0 = 6'h15;
	localparam vio_addr_t FA_FIFO_FULL = 6'h1A;
	localparam vio_addr_t FA_FIFO_EMPTY = 6'h1B;
	localparam vio_addr_t FA_LOCK = 6'h1C;
	localparam vio_addr_t FA_PASS = 6'h1D;
	localparam vio_addr_t FA_OVERRUN = 6'h1E;
	localparam vio_addr_t FA_CHK_ERR = 6'h1F;
	localparam vio_addr_t FA_EDH_FORCE = 6'h20;
	localparam vio_addr_t FA_SEL0 = 6'h21;
	localparam vio_addr_t FA_EDH_EN = 6'h27;
	localparam vio_addr_t FA_GEN_EN = 6'h28;
	localparam vio_addr_t FA_CHK_ATT = 6'h2A;
	localparam vio_addr_t FA_BAND_EN = 6'h2C;
	localparam vio_addr_t FA_DITHER = 6'h2D;
	localparam vio_addr_t FA_INSERT = 6'h2F;
	localparam int FMT_W = 5;
	localparam int SEL_W = 6;
	// Power-on pin assignment, pin 0 in the low slot.
	localparam vio_addr_t DEF_PIN [NPINS] = '{6'h00, 6'h00, 6'h00, FA_FMT0 + 6'h04,
		6'h00, FA_CRC_ERR, FA_PASS, FA_GEN_EN};
	localparam logic [1:0] PAT_BLACK = 2'h0;
	localparam logic [1:0] PAT_PLL = 2'h1;
	localparam logic [1:0] PAT_EQ = 2'h2;
	localparam logic [1:0] PAT_BARS = 2'h3;
	localparam logic [3:0] RAS_NTSC43 = 4'h0;
	localparam logic [3:0] RAS_NTSC169 = 4'h1;
	localparam logic [3:0] RAS_NTSC54 = 4'h2;
	localparam logic [3:0] RAS_PAL43 = 4'h4;
	localparam logic [3:0] RAS_PAL169 = 4'h5;
	localparam logic [3:0] RAS_PAL54 = 4'h6;
	localparam logic [SEL_W-1:0] BIST_SEL_A = 6'h03;
	localparam logic [SEL_W-1:0] BIST_SEL_B = 6'h11;
	typedef enum logic [1:0] {PT_BLACK, PT_PLL, PT_EQ, PT_BARS} vio_pat_e;
	typedef enum logic [2:0] {RT_NONE, RT_NTSC, RT_PAL, RT_HD} vio_std_e;
	typedef enum logic [1:0] {WR_NONE, WR_27, WR_36, WR_54} vio_rate_e;
	// Internal indicators that can be routed to pins.
	typedef struct packed {
		logic ff_err;
		logic ap_err;
		logic anc_err;
		logic crc_err;
		logic sav;
		logic eav;
		logic nsync;
		logic h_bit;
		logic f_bit;
		logic [FMT_W-1:0] fmt;
		logic fifo_full;
		logic fifo_empty;
		logic lock;
		logic pass;
		logic overrun;
		logic chk_err;
	} vio_stat_s;
	// Controls gathered from input pins.
	typedef struct packed {
		logic edh_force;
		logic [SEL_W-1:0] sel;
		logic edh_en;
		logic gen_en;
		logic chk_attach;
		logic band_en;
		logic dither_en;
		logic insert_en;
	} vio_ctrl_s;
	// Decoded pattern generator setting.
	typedef struct packed {
		vio_pat_e pat;
		vio_std_e std;
		vio_rate_e rate;
		logic wide;
		logic hd;
		logic [2:0] hd_ras;
		logic valid;
	} vio_pcfg_s;
endpackage

// ==== vio_pat_dec.sv ====
// Decodes the six-bit select word into pattern, standard and word rate.
module vio_pat_dec
	import vio_pkg::*;
(
	// Select word.
	input wire logic [vio_pkg::SEL_W-1:0] sel_i,
	// Decoded setting.
	output vio_pkg::vio_pcfg_s cfg_o
);
	always_comb begin
		cfg_o = '0;
		// (RULE1) pattern from low bits.
		cfg_o.pat = vio_pat_e'(sel_i[1:0]);
		cfg_o.valid = 1'b1;
		if (sel_i[5]) begin
			// (RULE20) HD raster select.
			cfg_o.hd = 1'b1;
			cfg_o.std = RT_HD;
			cfg_o.hd_ras = sel_i[4:2];
		end else begin
			unique case (sel_i[5:2])
				// (RULE2) NTSC 4:3.
				RAS_NTSC43: begin
					cfg_o.std = RT_NTSC;
					cfg_o.rate = WR_27;
				end
				// (RULE3) PAL 4:3.
				RAS_PAL43: begin
					cfg_o.std = RT_PAL;
					cfg_o.rate = WR_27;
				end
				// (RULE4) NTSC wide.
				RAS_NTSC169: begin
					cfg_o.std = RT_NTSC;
					cfg_o.rate = WR_36;
					cfg_o.wide = 1'b1;
				end
				// (RULE5) PAL wide.
				RAS_PAL169: begin
					cfg_o.std = RT_PAL;
					cfg_o.rate = WR_36;
					cfg_o.wide = 1'b1;
				end
				// (RULE6) NTSC 54 MHz.
				RAS_NTSC54: begin
					cfg_o.std = RT_NTSC;
					cfg_o.rate = WR_54;
				end
				// (RULE7) PAL 54 MHz.
				RAS_PAL54: begin
					cfg_o.std = RT_PAL;
					cfg_o.rate = WR_54;
				end
				// Unlisted SD codes are flagged invalid rather than guessed.
				default: begin
					cfg_o.valid = 1'b0;
				end
			endcase
		end
	end
endmodule

// ==== vio_port_map.sv ====
// Multi-function I/O port: each pin carries a function address.
module vio_port_map
	import vio_pkg::*;
#(
	parameter int PINS = vio_pkg::NPINS
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Pin address load.
	input wire logic cfg_we_i,
	input wire logic [2:0] cfg_pin_i,
	input wire vio_pkg::vio_addr_t cfg_addr_i,
	// Internal indicators.
	input wire vio_pkg::vio_stat_s stat_i,
	// Self-test request.
	input wire logic bist_start_i,
	// Pins.
	input wire logic [PINS-1:0] pin_i,
	output logic [PINS-1:0] pin_o,
	output logic [PINS-1:0] pin_oe_o,
	// Control and decoded pattern setting.
	output vio_pkg::vio_ctrl_s ctrl_o,
	output vio_pkg::vio_pcfg_s pcfg_o,
	output logic [vio_pkg::SEL_W-1:0] sel_o,
	output logic bist_busy_o
);
	typedef struct packed {
		vio_addr_t [PINS-1:0] addr;
		logic [PINS-1:0] s1;
		logic [PINS-1:0] s2;
		logic [PINS-1:0] pin;
		logic [PINS-1:0] oe;
		vio_ctrl_s ctrl;
		vio_pcfg_s pcfg;
		logic [SEL_W-1:0] sel;
		logic [1:0] bist;
		logic busy;
	} vio_state_s;
	vio_state_s q, d;
	vio_ctrl_s ctrl_c;
	vio_pcfg_s dec_cfg;
	logic [SEL_W-1:0] sel_eff;
	logic [PINS-1:0] drv_c;
	logic [PINS-1:0] oe_c;

	// Output value of a function address; reserved addresses give no drive.
	function automatic logic [1:0] out_fn(input vio_addr_t a, input vio_stat_s s);
		logic [1:0] r;
		r = 2'b00;
		unique case (a)
			// (RULE11) EDH and CRC flags.
			FA_FF_ERR: r = {1'b1, s.ff_err};
			FA_AP_ERR: r = {1'b1, s.ap_err};
			FA_ANC_ERR: r = {1'b1, s.anc_err};
			FA_CRC_ERR: r = {1'b1, s.crc_err};
			// (RULE13) timing indicators.
			FA_SAV: r = {1'b1, s.sav};
			FA_EAV: r = {1'b1, s.eav};
			FA_NSYNC: r = {1'b1, s.nsync};
			FA_H: r = {1'b1, s.h_bit};
			FA_F: r = {1'b1, s.f_bit};
			// (RULE15) FIFO, lock and test status.
			FA_FIFO_FULL: r = {1'b1, s.fifo_full};
			FA_FIFO_EMPTY: r = {1'b1, s.fifo_empty};
			FA_LOCK: r = {1'b1, s.lock};
			FA_PASS: r = {1'b1, s.pass};
			FA_OVERRUN: r = {1'b1, s.overrun};
			FA_CHK_ERR: r = {1'b1, s.chk_err};
			default: begin
				// (RULE14) format code bits ascend with address.
				if (a >= FA_FMT0 && a < FA_FMT0 + 6'(FMT_W)) begin
					r = {1'b1, s.fmt[3'(a - FA_FMT0)]};
				end
				// (RULE12) other low addresses stay undriven.
			end
		endcase
		return r;
	endfunction

	// (RULE10) per-pin direction and drive from each address.
	for (genvar p = 0; p < PINS; p++) begin : g_pin
		assign {oe_c[p], drv_c[p]} = out_fn(q.addr[p], stat_i);
	end

	// Gather input pins; later pins win when two share one address.
	always_comb begin
		ctrl_c = '0;
		for (int p = 0; p < PINS; p++) begin
			// (RULE16) generator and EDH inputs.
			if (q.addr[p] == FA_EDH_FORCE) ctrl_c.edh_force = q.s2[p];
			if (q.addr[p] >= FA_SEL0 && q.addr[p] < FA_SEL0 + 6'(SEL_W)) begin
				ctrl_c.sel[3'(q.addr[p] - FA_SEL0)] = q.s2[p];
			end
			if (q.addr[p] == FA_EDH_EN) ctrl_c.edh_en = q.s2[p];
			if (q.addr[p] == FA_GEN_EN) ctrl_c.gen_en = q.s2[p];
			// (RULE17) ancillary and filter inputs.
			if (q.addr[p] == FA_CHK_ATT) ctrl_c.chk_attach = q.s2[p];
			if (q.addr[p] == FA_BAND_EN) ctrl_c.band_en = q.s2[p];
			if (q.addr[p] == FA_DITHER) ctrl_c.dither_en = q.s2[p];
			if (q.addr[p] == FA_INSERT) ctrl_c.insert_en = q.s2[p];
			// (RULE19) reserved addresses touch no control.
		end
	end

	// (RULE8) self-test overrides the select word with its two patterns.
	always_comb begin
		unique case (q.bist)
			2'h1: sel_eff = BIST_SEL_A;
			2'h2: sel_eff = BIST_SEL_B;
			default: sel_eff = ctrl_c.sel;
		endcase
	end

	vio_pat_dec u_dec (
		.sel_i(sel_eff),
		.cfg_o(dec_cfg)
	);

	// Next state.
	always_comb begin
		d = q;
		d.s1 = pin_i;
		d.s2 = q.s1;
		if (cfg_we_i && 32'(cfg_pin_i) < PINS) begin
			d.addr[cfg_pin_i] = cfg_addr_i;
		end
		// (RULE19) undriven pins show low, like the pull-down.
		d.pin = drv_c & oe_c;
		d.oe = oe_c;
		d.ctrl = ctrl_c;
		d.pcfg = dec_cfg;
		d.sel = sel_eff;
		// Each self-test pattern is held one cycle; HD test uses bars of its raster.
		unique case (q.bist)
			2'h0: if (bist_start_i) d.bist = 2'h1;
			2'h1: d.bist = 2'h2;
			default: d.bist = 2'h0;
		endcase
		// Busy is registered beside sel, so it spans exactly the cycles showing an SD test pattern; HD bars leave it low.
		d.busy = (q.bist != 2'h0);
		// (RULE9) HD self-test keeps the raster and forces color bars; refused while the SD self-test state is not idle.
		if (bist_start_i && ctrl_c.sel[5] && q.bist == 2'h0) begin
			d.bist = 2'h0;
			d.sel = {ctrl_c.sel[5:2], PAT_BARS};
			d.pcfg.pat = PT_BARS;
		end
	end

	// Register the state; reset restores the power-on pin map.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
			// (RULE18) power-on defaults.
			for (int p = 0; p < PINS; p++) begin
				q.addr[p] <= (p < NPINS) ? DEF_PIN[p] : 6'h00;
			end
		end else begin
			q <= d;
		end
	end

	assign pin_o = q.pin;
	assign pin_oe_o = q.oe;
	assign ctrl_o = q.ctrl;
	assign pcfg_o = q.pcfg;
	assign sel_o = q.sel;
	assign bist_busy_o = q.busy;

	// (RULE10) a pin drives exactly when its address is an output one.
	pin_dir_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		($past(rst_b_i) && q.addr[5] == $past(q.addr[5])) |->
		(pin_oe_o[5] == (q.addr[5] < FA_EDH_FORCE
		&& $past(oe_c[5])))) else $error("pin direction wrong");
	// (RULE11) CRC error follows to its pin one cycle later.
	crc_route_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(q.addr[0] == FA_CRC_ERR) ##1 (q.addr[0] == FA_CRC_ERR) |->
		pin_o[0] == $past(stat_i.crc_err)) else $error("crc routing wrong");
	// (RULE12) reserved low addresses never drive.
	rsv_low_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		($past(q.addr[0]) > FA_CRC_ERR && $past(q.addr[0]) < FA_SAV) |-> !pin_oe_o[0])
		else $error("reserved address drives");
	// (RULE13) H bit routing.
	h_route_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$past(q.addr[0] == FA_H) |-> pin_o[0] == $past(stat_i.h_bit))
		else $error("h bit routing wrong");
	// (RULE14) format bit 4 routing.
	fmt_route_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$past(rst_b_i) && $past(q.addr[3] == FA_FMT0 + 6'h04) |->
		pin_o[3] == $past(stat_i.fmt[4]))
		else $error("format bit routing wrong");
	// (RULE15) pass flag routing.
	pass_route_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$past(rst_b_i) && $past(q.addr[6] == FA_PASS) |->
		pin_o[6] == $past(stat_i.pass))
		else $error("pass routing wrong");
	// (RULE16) generator enable takes the synchronised pin three edges on.
	sequence gen_pin_s;
		(q.addr[7] == FA_GEN_EN)[*3];
	endsequence
	gen_in_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		gen_pin_s |-> ctrl_o.gen_en == $past(pin_i[7], 3)) else $error("enable input wrong");
	// (RULE17) inputs never drive the pin.
	in_nodrv_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$past(q.addr[0] >= FA_EDH_FORCE) |-> !pin_oe_o[0]) else $error("input pin drives");
	// (RULE8) self-test walks NTSC bars then PAL PLL path.
	bist_seq_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(q.bist == 2'h0 && bist_start_i && !ctrl_c.sel[5]) |-> ##2 sel_o == BIST_SEL_A
		##1 sel_o == BIST_SEL_B) else $error("self-test order wrong");
	// (RULE1) decoded pattern matches low select bits.
	pat_dec_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		pcfg_o.pat == vio_pat_e'(sel_o[1:0])) else $error("pattern decode wrong");
endmodule

// ==== vio_host_model.sv ====
// Host logic on the board: senses output pins and drives the input pins.
module vio_host_model (
	// Host side levels.
	input wire logic [vio_pkg::NPINS-1:0] drive_i,
	// Device side pin drive.
	input wire logic [vio_pkg::NPINS-1:0] dev_pin_i,
	input wire logic [vio_pkg::NPINS-1:0] dev_oe_i,
	// Resolved pin levels.
	output logic [vio_pkg::NPINS-1:0] level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import vio_pkg::*;

	// host drives inputs.
	// The host backs off wherever the device drives, so no pin is ever fought over.
	assign level_o = (dev_oe_i & dev_pin_i) | (~dev_oe_i & drive_i);
endmodule

// ==== video_io_port_function_map_tb.sv ====
module video_io_port_function_map_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import vio_pkg::*;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end

	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic cfg_we_q = 1'b0;
	logic [2:0] cfg_pin_q = '0;
	vio_addr_t cfg_addr_q = '0;
	vio_stat_s stat_q = '0;
	logic bist_q = 1'b0;
	logic [NPINS-1:0] host_q = '0;
	logic [NPINS-1:0] lvl;
	logic [NPINS-1:0] pin_o;
	logic [NPINS-1:0] pin_oe;
	vio_ctrl_s ctrl;
	vio_pcfg_s pcfg;
	logic [SEL_W-1:0] sel;
	logic busy;
	int failures = 0;
	int n_checks = 0;
	logic [$bits(vio_stat_s)-1:0] sv;
	logic [$bits(vio_ctrl_s)-1:0] cv;
	logic [SEL_W-1:0] sx;
	logic [9:0] pe;
	logic [SEL_W-1:0] sh [7];
	logic bh [7];
	// Output addresses and the status bit each one must carry.
	localparam vio_addr_t OA [20] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h0D, 6'h0E, 6'h0F, 6'h11,
		6'h12, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F};
	localparam int OB [20] = '{19, 18, 17, 16, 15, 14, 13, 12, 11, 6, 7, 8, 9, 10, 5, 4, 3, 2, 1, 0};
	// Input addresses and the control bit each one must set.
	localparam vio_addr_t IA [13] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27,
		6'h28, 6'h2A, 6'h2C, 6'h2D, 6'h2F};
	localparam int IB [13] = '{12, 6, 7, 8, 9, 10, 11, 5, 4, 3, 2, 1, 0};
	localparam vio_addr_t RA [5] = '{6'h00, 6'h05, 6'h08, 6'h0C, 6'h29};
	localparam logic [3:0] RS [6] = '{4'h0, 4'h4, 4'h1, 4'h5, 4'h2, 4'h6};

	// Free-running 25 MHz clock.
	always #20 clock_i = ~clock_i;

	vio_port_map #(.PINS(NPINS)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_we_i(cfg_we_q),
		.cfg_pin_i(cfg_pin_q), .cfg_addr_i(cfg_addr_q), .stat_i(stat_q), .bist_start_i(bist_q),
		.pin_i(lvl), .pin_o(pin_o), .pin_oe_o(pin_oe), .ctrl_o(ctrl), .pcfg_o(pcfg),
		.sel_o(sel), .bist_busy_o(busy));

	vio_host_model host (.drive_i(host_q), .dev_pin_i(pin_o), .dev_oe_i(pin_oe), .level_o(lvl));

	// Loads one pin's function address; the strobe drops on the following edge.
	task automatic cfg(input logic [2:0] p, input vio_addr_t a);
		@(posedge clock_i);
		cfg_we_q <= 1'b1;
		cfg_pin_q <= p;
		cfg_addr_q <= a;
		@(posedge clock_i);
		cfg_we_q <= 1'b0;
	endtask

	// Applies status and host levels, then waits past the pin synchroniser.
	task automatic put(input logic [$bits(vio_stat_s)-1:0] s, input logic [NPINS-1:0] h);
		@(posedge clock_i);
		stat_q <= s;
		host_q <= h;
		repeat (4) @(posedge clock_i);
		#1;
	endtask

	// Single exit point for both the normal end and the watchdog.
	task automatic print_verdict();
		if (failures == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// The whole sequence needs well under 2000 cycles.
	initial begin
		repeat (20000) @(posedge clock_i);
		failures++;
		print_verdict();
	end

	initial begin
		repeat (5) @(posedge clock_i);
		rst_b_i <= 1'b1;
		sv = '0;
		sv[16] = 1'b1;
		sv[2] = 1'b1;
		sv[10] = 1'b1;
		put(sv, 8'h80);
		`CHK(pin_oe, 8'h68)
		`CHK(pin_o, 8'h68)
		`CHK(ctrl.gen_en, 1'b1)
		// output routing; inverted status catches a wrong bit.
		for (int i = 0; i < 20; i++) begin
			cfg(3'd0, OA[i]);
			sv = '0;
			sv[OB[i]] = 1'b1;
			put(sv, 8'h00);
			`CHK({pin_oe[0], pin_o[0]}, 2'b11)
			put(~sv, 8'h00);
			`CHK(pin_o[0], 1'b0)
		end
		cfg(3'd7, 6'h00);
		for (int i = 0; i < 5; i++) begin
			cfg(3'd0, RA[i]);
			put('1, 8'h01);
			cv = '0;
			`CHK({pin_oe[0], pin_o[0]}, 2'b00)
			`CHK(ctrl, cv)
		end
		for (int i = 0; i < 13; i++) begin
			cfg(3'd0, IA[i]);
			put('0, 8'h01);
			cv = '0;
			cv[IB[i]] = 1'b1;
			`CHK(ctrl, cv)
			`CHK(pin_oe[0], 1'b0)
		end
		// select word decode through six input pins.
		for (int p = 0; p < 6; p++) begin
			cfg(3'(p), vio_addr_t'(6'h21 + p));
		end
		for (int r = 0; r < 6; r++) begin
			for (int t = 0; t < 4; t++) begin
				sx = {RS[r], 2'(t)};
				put('0, {2'b00, sx});
				pe = {vio_pat_e'(t), RS[r][2] ? RT_PAL : RT_NTSC,
					RS[r][1] ? WR_54 : (RS[r][0] ? WR_36 : WR_27), RS[r][0], 1'b0, 1'b1};
				`CHK(sel, sx)
				`CHK({pcfg.pat, pcfg.std, pcfg.rate, pcfg.wide, pcfg.hd, pcfg.valid}, pe)
			end
		end
		put('0, 8'h3B);
		`CHK({pcfg.hd, pcfg.hd_ras, pcfg.pat, pcfg.valid}, {1'b1, 3'h6, PT_BARS, 1'b1})
		put('0, 8'h0F);
		`CHK(pcfg.valid, 1'b0)
		// SD self-test; start stays high two more edges, which the running test sequence must refuse.
		put('0, 8'h16);
		@(posedge clock_i);
		bist_q <= 1'b1;
		for (int k = 1; k < 7; k++) begin
			@(posedge clock_i);
			if (k == 3) begin
				bist_q <= 1'b0;
			end
			#1;
			sh[k] = sel;
			bh[k] = busy;
		end
		`CHK({bh[1], sh[1]}, {1'b0, 6'h16})
		`CHK({bh[2], sh[2]}, {1'b1, 6'h03})
		`CHK({bh[3], sh[3]}, {1'b1, 6'h11})
		`CHK({bh[4], sh[4]}, {1'b0, 6'h16})
		`CHK({bh[6], sh[6]}, {1'b0, 6'h16})
		// HD self-test shows bars of the chosen raster for one cycle.
		put('0, 8'h3A);
		@(posedge clock_i);
		bist_q <= 1'b1;
		@(posedge clock_i);
		bist_q <= 1'b0;
		#1;
		`CHK({busy, sel, pcfg.pat}, {1'b0, 6'h3B, PT_BARS})
		@(posedge clock_i);
		#1;
		`CHK(sel, 6'h3A)
		print_verdict();
	end
endmodule
